// >>> core/fwbp_device.sv
// flash command sequencer: write buffer, dynamic locks, identification, burst read
module fwbp_device
  import fwbp_pkg::*;
#(
  parameter int MEM_AW = 12
) (
  input wire logic CORE_CLK, // 250 MHz clock
  input wire logic RST, // synchronous reset, high
  fwbp_if.device BUS, // flash pins
  output logic BUSY, // embedded program running or suspended
  output logic ABORTED // buffer operation aborted, awaiting reset sequence
);
  // ------------------------------------------------------------
  // pin decode
  // ------------------------------------------------------------
  fwbp_state_e state_q;
  logic we_prev_q;
  logic oe_prev_q;
  logic [ADDR_W-1:0] addr_q;
  logic [1:0] unlock_q;
  logic wr_take;
  logic cmd_take;
  logic rd_start;
  logic [DATA_W-1:0] wdata;
  logic [SECT_W-1:0] wsect;
  logic [NUM_SECT-1:0] lock_q;
  logic [SECT_W-1:0] sect_q;
  logic [ADDR_W-PAGE_LSB-1:0] page_q;
  logic page_set_q;
  logic [DATA_W-1:0] buf_data_q [BUF_WORDS];
  logic [BUF_WORDS-1:0] buf_valid_q;
  logic [BUF_AW-1:0] left_q;
  logic [ADDR_W-1:0] last_addr_q;
  logic [DATA_W-1:0] last_data_q;
  logic [CNT_W-1:0] op_cnt_q;
  logic [BANK_W-1:0] id_bank_q;
  logic [DATA_W-1:0] mem [1 << MEM_AW];
  logic target_locked;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      we_prev_q <= 1'b1;
      oe_prev_q <= 1'b1;
    end else begin
      we_prev_q <= BUS.write_enable_n;
      oe_prev_q <= BUS.output_enable_n;
    end
  end

  // address phase: avd and ce low, oe high
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      addr_q <= '0;
    end else if (!BUS.chip_enable_n && !BUS.address_valid_n && BUS.output_enable_n) begin
      addr_q <= {BUS.addr_hi, BUS.adq};
    end
  end

  // a write is taken on the first cycle of we low with ce low and oe high
  assign wr_take = !BUS.chip_enable_n && !BUS.write_enable_n && BUS.output_enable_n
                   && we_prev_q;
  assign wdata = BUS.adq;
  assign wsect = addr_q[ADDR_W-1:SECT_LSB];
  assign cmd_take = wr_take && (unlock_q == 2'h2);
  assign rd_start = !BUS.chip_enable_n && !BUS.output_enable_n && oe_prev_q;
  // pin low locks everything regardless of the dynamic bits
  assign target_locked = !BUS.protect_accel_pin || !lock_q[wsect];

  // ------------------------------------------------------------
  // unlock cycle tracking
  // ------------------------------------------------------------
  // unlock is only honoured where a new command may start, so identification
  // cannot be entered while a program is loading, running or suspended
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      unlock_q <= 2'h0;
    end else if (state_q != FWBP_READ && state_q != FWBP_IDENT && state_q != FWBP_ABORT) begin
      unlock_q <= 2'h0;
    end else if (wr_take) begin
      if (unlock_q == 2'h0 && addr_q[UNLOCK_AW-1:0] == UNLOCK1_ADDR && wdata == UNLOCK1_DATA) begin
        unlock_q <= 2'h1;
      end else if (unlock_q == 2'h1 && addr_q[UNLOCK_AW-1:0] == UNLOCK2_ADDR
                   && wdata == UNLOCK2_DATA) begin
        unlock_q <= 2'h2;
      end else begin
        unlock_q <= 2'h0;
      end
    end
  end

  // ------------------------------------------------------------
  // command state machine
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state_q <= FWBP_READ;
      op_cnt_q <= '0;
      id_bank_q <= '0;
    end else begin
      unique case (state_q)
        FWBP_READ, FWBP_IDENT: begin
          if (cmd_take && wdata == CMD_BUF_LOAD) begin
            state_q <= FWBP_BUF_CNT;
          end else if (cmd_take && wdata == CMD_WORD_PROG) begin
            state_q <= FWBP_WORD_DATA;
          end else if (cmd_take && wdata == CMD_IDENT) begin
            state_q <= FWBP_IDENT;
            id_bank_q <= addr_q[ADDR_W-1:BANK_LSB];
          end else if (state_q == FWBP_IDENT && wr_take && unlock_q == 2'h0
                       && wdata == CMD_EXIT) begin
            state_q <= FWBP_READ;
          end
        end
        FWBP_BUF_CNT: begin
          if (wr_take) begin
            if (wdata > DATA_W'(BUF_WORDS - 1) || wsect != sect_q) begin
              state_q <= FWBP_ABORT;
            end else begin
              state_q <= FWBP_BUF_LOAD;
            end
          end
        end
        FWBP_BUF_LOAD: begin
          if (wr_take) begin
            if (wsect != sect_q
                || (page_set_q && addr_q[ADDR_W-1:PAGE_LSB] != page_q)) begin
              state_q <= FWBP_ABORT;
            end else if (left_q == '0) begin
              state_q <= FWBP_BUF_CONF;
            end
          end
        end
        FWBP_BUF_CONF: begin
          if (wr_take) begin
            op_cnt_q <= '0;
            if (wdata != CMD_BUF_CONFIRM || wsect != sect_q) begin
              state_q <= FWBP_ABORT;
            end else if (target_locked) begin
              state_q <= FWBP_PROT;
            end else begin
              state_q <= FWBP_BUSY;
            end
          end
        end
        FWBP_WORD_DATA: begin
          if (wr_take) begin
            op_cnt_q <= '0;
            state_q <= target_locked ? FWBP_PROT : FWBP_BUSY;
          end
        end
        FWBP_BUSY: begin
          if (wr_take && wdata == CMD_SUSPEND) begin
            state_q <= FWBP_SUSP;
          end else if (op_cnt_q == CNT_W'(PROG_CYC - 1)) begin
            state_q <= FWBP_READ;
          end else begin
            op_cnt_q <= op_cnt_q + 1'b1;
          end
        end
        FWBP_SUSP: begin
          if (wr_take && wdata == CMD_RESUME) begin
            state_q <= FWBP_BUSY;
          end
        end
        FWBP_PROT: begin
          if (op_cnt_q == CNT_W'(PROT_CYC - 1)) begin
            state_q <= FWBP_READ;
          end else begin
            op_cnt_q <= op_cnt_q + 1'b1;
          end
        end
        FWBP_ABORT: begin
          if (cmd_take && wdata == CMD_ABORT_RESET) begin
            state_q <= FWBP_READ;
          end
        end
        default: state_q <= FWBP_READ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // write buffer
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      sect_q <= '0;
      page_q <= '0;
      page_set_q <= 1'b0;
      buf_valid_q <= '0;
      left_q <= '0;
      last_addr_q <= '0;
      last_data_q <= '0;
    end else if (cmd_take && (wdata == CMD_BUF_LOAD || wdata == CMD_WORD_PROG)) begin
      sect_q <= wsect;
      page_set_q <= 1'b0;
      buf_valid_q <= '0;
      left_q <= '0;
    end else if (state_q == FWBP_BUF_CNT && wr_take) begin
      left_q <= wdata[BUF_AW-1:0];
    end else if ((state_q == FWBP_BUF_LOAD || state_q == FWBP_WORD_DATA) && wr_take) begin
      if (!page_set_q) begin
        page_q <= addr_q[ADDR_W-1:PAGE_LSB];
        page_set_q <= 1'b1;
      end
      // a repeated location is overwritten and still counts as a load
      buf_data_q[addr_q[BUF_AW-1:0]] <= wdata;
      buf_valid_q[addr_q[BUF_AW-1:0]] <= 1'b1;
      left_q <= left_q - 1'b1;
      last_addr_q <= addr_q;
      last_data_q <= wdata;
    end
  end

  // array image is a small window of the address space to keep simulation cheap
  always_ff @(posedge CORE_CLK) begin
    if (state_q == FWBP_BUSY && op_cnt_q == CNT_W'(PROG_CYC - 1)) begin
      for (int i = 0; i < BUF_WORDS; i++) begin
        if (buf_valid_q[i]) begin
          mem[MEM_AW'({page_q, BUF_AW'(i)})] <= buf_data_q[i];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // dynamic sector locks
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      lock_q <= '1;
    end else if (cmd_take && state_q == FWBP_READ) begin
      if (wdata == CMD_LOCK_SET) begin
        lock_q[wsect] <= 1'b0;
      end else if (wdata == CMD_LOCK_CLEAR) begin
        lock_q[wsect] <= 1'b1;
      end else if (wdata == CMD_LOCKREG_PROG) begin
        lock_q <= '1;
      end
    end
  end

  // ------------------------------------------------------------
  // burst read path
  // ------------------------------------------------------------
  logic [ADDR_W-1:0] raddr_q;
  logic [LAT_W-1:0] lat_q;
  logic rdy_q;
  logic tog_q;
  logic [DATA_W-1:0] dout_q;
  logic [DATA_W-1:0] rd_word;
  logic status_hit;
  logic ident_hit;

  // only the bank being programmed answers with status, others keep array data
  assign status_hit = (state_q == FWBP_BUSY || state_q == FWBP_ABORT || state_q == FWBP_PROT)
                      && raddr_q[ADDR_W-1:BANK_LSB] == last_addr_q[ADDR_W-1:BANK_LSB];
  assign ident_hit = state_q == FWBP_IDENT && raddr_q[ADDR_W-1:BANK_LSB] == id_bank_q;

  always_comb begin
    rd_word = mem[raddr_q[MEM_AW-1:0]];
    if (status_hit) begin
      rd_word = '0;
      rd_word[ST_POLL_BIT] = ~last_data_q[ST_POLL_BIT];
      rd_word[ST_TOGGLE_BIT] = tog_q;
      rd_word[ST_FAIL_BIT] = 1'b0;
      rd_word[ST_TOGGLE2_BIT] = tog_q;
      rd_word[ST_ABORT_BIT] = state_q == FWBP_ABORT;
    end else if (ident_hit) begin
      unique case (raddr_q[1:0])
        ID_SEL_MAKER: rd_word = ID_MAKER_CODE;
        ID_SEL_PART: rd_word = ID_PART_CODE;
        default: rd_word = {{(DATA_W-1){1'b0}}, ~lock_q[raddr_q[ADDR_W-1:SECT_LSB]]};
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST || BUS.chip_enable_n) begin
      lat_q <= '0;
      rdy_q <= 1'b0;
    end else if (rd_start) begin
      raddr_q <= addr_q;
      lat_q <= LAT_W'(READ_LAT_CYC);
      rdy_q <= 1'b0;
    end else if (!BUS.output_enable_n && (lat_q == LAT_W'(1) || rdy_q)) begin
      dout_q <= rd_word;
      raddr_q <= raddr_q + 1'b1;
      lat_q <= '0;
      rdy_q <= 1'b1;
    end else if (lat_q != '0) begin
      lat_q <= lat_q - 1'b1;
    end
  end

  // status toggles once per read access to any bank while busy, aborted or polling
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      tog_q <= 1'b0;
    end else if (rd_start && (state_q == FWBP_BUSY || state_q == FWBP_ABORT
                 || state_q == FWBP_PROT)) begin
      tog_q <= ~tog_q;
    end
  end

  assign BUS.rdy = rdy_q;
  assign BUS.dev_adq = dout_q;
  assign BUS.dev_adq_oe = !BUS.chip_enable_n && !BUS.output_enable_n;
  assign BUSY = state_q == FWBP_BUSY || state_q == FWBP_SUSP;
  assign ABORTED = state_q == FWBP_ABORT;
endmodule // fwbp_device

// >>> core/fwbp_host.sv
// host controller end: turns single word requests into flash bus cycles
module fwbp_host
  import fwbp_pkg::*;
(
  input wire logic CORE_CLK, // 250 MHz clock
  input wire logic RST, // synchronous reset, high
  input wire logic CMD_VALID, // request present
  output logic CMD_READY, // request accepted this cycle
  input wire logic CMD_WRITE, // 1 write, 0 read
  input wire logic [ADDR_W-1:0] CMD_ADDR, // word address
  input wire logic [DATA_W-1:0] CMD_WDATA, // write data or command word
  output logic RSP_VALID, // read data pulse
  output logic [DATA_W-1:0] RSP_RDATA, // read data
  input wire logic PROTECT_LEVEL, // level to put on the protect pin
  fwbp_if.host BUS // flash pins
);
  // ------------------------------------------------------------
  // bus cycle sequencer
  // ------------------------------------------------------------
  fwbp_host_state_e state_q;
  logic write_q;
  logic [DATA_W-1:0] wdata_q;
  logic ce_n_q;
  logic avd_n_q;
  logic we_n_q;
  logic oe_n_q;
  logic [HI_W-1:0] hi_q;
  logic [DATA_W-1:0] adq_q;
  logic adq_oe_q;
  logic rsp_valid_q;
  logic [DATA_W-1:0] rsp_data_q;

  assign CMD_READY = state_q == FWBP_H_IDLE;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state_q <= FWBP_H_IDLE;
      write_q <= 1'b0;
      wdata_q <= '0;
      ce_n_q <= 1'b1;
      avd_n_q <= 1'b1;
      we_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      hi_q <= '0;
      adq_q <= '0;
      adq_oe_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= '0;
    end else begin
      rsp_valid_q <= 1'b0;
      unique case (state_q)
        FWBP_H_IDLE: begin
          if (CMD_VALID) begin
            write_q <= CMD_WRITE;
            wdata_q <= CMD_WDATA;
            ce_n_q <= 1'b0;
            avd_n_q <= 1'b0;
            hi_q <= CMD_ADDR[ADDR_W-1:DATA_W];
            adq_q <= CMD_ADDR[DATA_W-1:0];
            adq_oe_q <= 1'b1;
            state_q <= FWBP_H_ADDR;
          end
        end
        FWBP_H_ADDR: begin
          avd_n_q <= 1'b1;
          if (write_q) begin
            we_n_q <= 1'b0;
            adq_q <= wdata_q;
            state_q <= FWBP_H_WRITE;
          end else begin
            oe_n_q <= 1'b0;
            adq_oe_q <= 1'b0;
            state_q <= FWBP_H_READ;
          end
        end
        FWBP_H_WRITE: begin
          we_n_q <= 1'b1;
          ce_n_q <= 1'b1;
          adq_oe_q <= 1'b0;
          state_q <= FWBP_H_IDLE;
        end
        FWBP_H_READ: begin
          // first word is valid once ready is seen high
          if (BUS.rdy) begin
            rsp_data_q <= BUS.adq;
            rsp_valid_q <= 1'b1;
            oe_n_q <= 1'b1;
            ce_n_q <= 1'b1;
            state_q <= FWBP_H_IDLE;
          end
        end
      endcase
    end
  end

  assign BUS.chip_enable_n = ce_n_q;
  assign BUS.address_valid_n = avd_n_q;
  assign BUS.write_enable_n = we_n_q;
  assign BUS.output_enable_n = oe_n_q;
  assign BUS.addr_hi = hi_q;
  assign BUS.host_adq = adq_q;
  assign BUS.host_adq_oe = adq_oe_q;
  assign BUS.protect_accel_pin = PROTECT_LEVEL;
  assign RSP_VALID = rsp_valid_q;
  assign RSP_RDATA = rsp_data_q;
endmodule // fwbp_host

// >>> core/fwbp_if.sv
// multiplexed address/data flash pins joining host controller and flash device
interface fwbp_if;
  import fwbp_pkg::*;
  logic chip_enable_n;
  logic address_valid_n;
  logic write_enable_n;
  logic output_enable_n;
  logic protect_accel_pin;
  logic [HI_W-1:0] addr_hi;
  logic [DATA_W-1:0] host_adq;
  logic host_adq_oe;
  logic [DATA_W-1:0] dev_adq;
  logic dev_adq_oe;
  logic rdy;
  logic [DATA_W-1:0] adq;

  // resolved shared lines; an undriven bus reads as zero
  assign adq = host_adq_oe ? host_adq : (dev_adq_oe ? dev_adq : '0);

  modport host (
    output chip_enable_n, address_valid_n, write_enable_n, output_enable_n,
    output protect_accel_pin, addr_hi, host_adq, host_adq_oe,
    input adq, rdy
  );
  modport device (
    input chip_enable_n, address_valid_n, write_enable_n, output_enable_n,
    input protect_accel_pin, addr_hi, adq,
    output dev_adq, dev_adq_oe, rdy
  );
endinterface

// >>> core/fwbp_pkg.sv
// constants, commands and state codes shared by the flash command logic and its host
// Operation
// - ready rises marking first valid burst word
// - other banks read normally during programming
// - host: address phase, then write phase
// - protect pin low locks every sector
// - write buffer holds at most 32 words
// - host: unlock, unlock, load, count
// - count above capacity aborts operation
// - first pair selects page from A21-A5
// - page or sector mismatch aborts operation
// - host loads pairs ascending within page
// - every load decrements; last value wins
// - confirm starts programming, anything else aborts
// - progress shown on status bits 7,6,5,2,1
// - abort: bit1 high, bit7 inverted, toggle
// - suspend/resume allowed; done returns to read
// - no identification entry while programming
// - identification codes from internal register
// - identification data only for given bank
// - dynamic locks reset to unprotected
// - lock-set protects, lock-clear unprotects, repeatable
// - lock register program clears dynamic locks
// - protected target: brief polling, then read
// - lock register program triggers lock reset
package fwbp_pkg;
  // ------------------------------------------------------------
  // bus geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int HI_W = ADDR_W - DATA_W;
  localparam int BUF_WORDS = 32;
  localparam int BUF_AW = 5;
  localparam int PAGE_LSB = 5;
  localparam int SECT_LSB = 15;
  localparam int SECT_W = ADDR_W - SECT_LSB;
  localparam int NUM_SECT = 1 << SECT_W;
  localparam int BANK_LSB = 19;
  localparam int BANK_W = ADDR_W - BANK_LSB;
  localparam int UNLOCK_AW = 12;
  // ------------------------------------------------------------
  // command words and unlock addresses
  // ------------------------------------------------------------
  localparam logic [UNLOCK_AW-1:0] UNLOCK1_ADDR = 12'h555;
  localparam logic [UNLOCK_AW-1:0] UNLOCK2_ADDR = 12'h2aa;
  localparam logic [DATA_W-1:0] UNLOCK1_DATA = 16'h00aa;
  localparam logic [DATA_W-1:0] UNLOCK2_DATA = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_BUF_LOAD = 16'h0025;
  localparam logic [DATA_W-1:0] CMD_BUF_CONFIRM = 16'h0029;
  localparam logic [DATA_W-1:0] CMD_WORD_PROG = 16'h00a0;
  localparam logic [DATA_W-1:0] CMD_IDENT = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_EXIT = 16'h00f0;
  localparam logic [DATA_W-1:0] CMD_ABORT_RESET = 16'h00f0;
  localparam logic [DATA_W-1:0] CMD_LOCK_SET = 16'h00e1;
  localparam logic [DATA_W-1:0] CMD_LOCK_CLEAR = 16'h00e2;
  localparam logic [DATA_W-1:0] CMD_LOCKREG_PROG = 16'h0041;
  localparam logic [DATA_W-1:0] CMD_SUSPEND = 16'h00b0;
  localparam logic [DATA_W-1:0] CMD_RESUME = 16'h0030;
  // identification codes: arbitrary values
  localparam logic [DATA_W-1:0] ID_MAKER_CODE = 16'h0a5a;
  localparam logic [DATA_W-1:0] ID_PART_CODE = 16'h0c3c;
  localparam logic [1:0] ID_SEL_MAKER = 2'h0;
  localparam logic [1:0] ID_SEL_PART = 2'h1;
  // ------------------------------------------------------------
  // status word bit positions
  // ------------------------------------------------------------
  localparam int ST_POLL_BIT = 7;
  localparam int ST_TOGGLE_BIT = 6;
  localparam int ST_FAIL_BIT = 5;
  localparam int ST_TOGGLE2_BIT = 2;
  localparam int ST_ABORT_BIT = 1;
  // ------------------------------------------------------------
  // timing at 250 MHz
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int READ_LAT_NS = 12;
  localparam int PROG_NS = 2000;
  localparam int PROT_POLL_NS = 40;
  localparam int READ_LAT_CYC = (READ_LAT_NS * CLK_MHZ + 999) / 1000;
  localparam int PROG_CYC = (PROG_NS * CLK_MHZ) / 1000;
  localparam int PROT_CYC = (PROT_POLL_NS * CLK_MHZ) / 1000;
  localparam int CNT_W = 12;
  localparam int LAT_W = 4;

  typedef enum logic [3:0] {
    FWBP_READ      = 4'h0,
    FWBP_BUF_CNT   = 4'h1,
    FWBP_BUF_LOAD  = 4'h2,
    FWBP_BUF_CONF  = 4'h3,
    FWBP_WORD_DATA = 4'h4,
    FWBP_BUSY      = 4'h5,
    FWBP_SUSP      = 4'h6,
    FWBP_ABORT     = 4'h7,
    FWBP_PROT      = 4'h8,
    FWBP_IDENT     = 4'h9
  } fwbp_state_e;

  typedef enum logic [1:0] {
    FWBP_H_IDLE  = 2'h0,
    FWBP_H_ADDR  = 2'h1,
    FWBP_H_WRITE = 2'h2,
    FWBP_H_READ  = 2'h3
  } fwbp_host_state_e;
endpackage

// >>> dv/flash_write_buffer_protect_tb_top.sv
// end-to-end bench: host controller driving the flash device
module flash_write_buffer_protect_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fwbp_pkg::*;
  localparam logic [21:0] A0 = 22'h000100; // bank 0
  localparam logic [21:0] A1 = 22'h080200; // bank 1, distinct array slot
  logic clk = 0, rst = 1, vld = 0, wr = 0, prot = 1, rv, rdy_c, busy, abrt;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wd = '0, rd, got, r1;
  int num_errors = 0, checks_done = 0;
  fwbp_if bus ();
  always #2 clk = ~clk;
  fwbp_host fwbp_host_inst (.CORE_CLK(clk), .RST(rst), .CMD_VALID(vld), .CMD_READY(rdy_c),
    .CMD_WRITE(wr), .CMD_ADDR(addr), .CMD_WDATA(wd), .RSP_VALID(rv), .RSP_RDATA(rd),
    .PROTECT_LEVEL(prot), .BUS(bus.host));
  fwbp_device fwbp_device_inst (.CORE_CLK(clk), .RST(rst), .BUS(bus.device), .BUSY(busy),
    .ABORTED(abrt));
  fwbp_props fwbp_props_inst (.CORE_CLK(clk), .RST(rst), .chip_enable_n(bus.chip_enable_n),
    .address_valid_n(bus.address_valid_n), .write_enable_n(bus.write_enable_n),
    .output_enable_n(bus.output_enable_n), .host_adq_oe(bus.host_adq_oe),
    .dev_adq_oe(bus.dev_adq_oe), .rdy(bus.rdy));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one request; reads leave the answer in got, writes wait out the bus turnaround
  task automatic op(input logic w, input logic [21:0] a, input logic [15:0] d);
    @(posedge clk);
    vld <= 1;
    wr <= w;
    addr <= a;
    wd <= d;
    got = 'x;
    @(negedge clk);
    while (rdy_c !== 1'b1) @(negedge clk);
    @(posedge clk);
    vld <= 0;
    for (int i = 0; i < 12; i++) begin
      @(negedge clk);
      if (!w && rv === 1'b1) got = rd;
      if ((!w && rv === 1'b1) || (w && i == 3)) break;
    end
  endtask
  task automatic seq(input logic [21:0] a, input logic [15:0] c);
    op(1, {10'h0, UNLOCK1_ADDR}, UNLOCK1_DATA);
    op(1, {10'h0, UNLOCK2_ADDR}, UNLOCK2_DATA);
    op(1, a, c);
  endtask
  // covers the brief status-polling window too, which does not raise busy
  task automatic idle;
    repeat (12) @(negedge clk);
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge clk);
    chk(16'(busy), 16'h0);
  endtask
  task automatic lockst(input logic [15:0] exp);
    seq(22'h0, CMD_IDENT);
    op(0, A0 + 22'h2, 16'h0);
    chk(16'(got[0]), exp);
    op(1, 22'h0, CMD_EXIT);
  endtask
  task automatic s_rww;
    seq(A0, CMD_WORD_PROG);
    op(1, A0, 16'h1234);
    idle;
    seq(A1, CMD_BUF_LOAD);
    op(1, A1, 16'h0002);
    op(1, A1, 16'h1111);
    op(1, A1, 16'h2222);
    op(1, A1 + 22'h1, 16'h0033);
    op(1, A1, CMD_BUF_CONFIRM);
    chk(16'(busy), 16'h1);
    op(0, A0, 16'h0);
    chk(got, 16'h1234);
    op(0, A1 + 22'h1, 16'h0);
    r1 = got;
    op(0, A1 + 22'h1, 16'h0);
    chk(16'({r1[7], r1[5], r1[1], r1[6] ^ got[6], r1[2] ^ got[2]}), 16'h13);
    seq(A0, CMD_IDENT); // refused while busy
    op(1, A1, CMD_SUSPEND);
    // a suspended program must outlast its own full run time
    repeat (600) @(negedge clk);
    chk(16'(busy), 16'h1);
    op(1, A1, CMD_RESUME);
    idle;
    op(0, A0, 16'h0);
    chk(got, 16'h1234);
    op(0, A1, 16'h0);
    chk(got, 16'h2222);
    op(0, A1 + 22'h1, 16'h0);
    chk(got, 16'h0033);
  endtask
  task automatic s_abort;
    for (int k = 0; k < 3; k++) begin
      seq(A1, CMD_BUF_LOAD);
      op(1, A1, (k == 0) ? 16'h0020 : 16'h0001); // count 32 asks for 33 words, one too many
      if (k > 0) op(1, A1 + 22'h2, 16'h0080);
      if (k == 1) op(1, A1 + 22'h20, 16'h00ff);
      if (k == 2) op(1, A1 + 22'h3, 16'h0081);
      if (k == 2) op(1, A1 + 22'h2, 16'h0000);
      chk(16'(abrt), 16'h1);
      op(0, A1 + 22'h2, 16'h0);
      r1 = got;
      op(0, A1 + 22'h2, 16'h0);
      chk(16'({r1[1], r1[5], r1[6] ^ got[6]}), 16'h5);
      if (k == 2) chk(16'(r1[7]), 16'h0);
      chk(16'(abrt), 16'h1);
      seq(A1, CMD_ABORT_RESET);
      chk(16'(abrt), 16'h0);
    end
  endtask
  task automatic s_ident;
    seq(22'h0, CMD_IDENT);
    op(0, 22'h0, 16'h0);
    chk(got, ID_MAKER_CODE);
    op(0, 22'h1, 16'h0);
    chk(got, ID_PART_CODE);
    op(0, A1, 16'h0);
    chk(got, 16'h2222);
    op(1, 22'h0, CMD_EXIT);
    op(0, 22'h1, 16'h0);
    chk(16'(got === ID_PART_CODE), 16'h0);
  endtask
  task automatic s_lock;
    lockst(16'h0);
    seq(A0, CMD_LOCK_SET);
    lockst(16'h1);
    seq(A0, CMD_WORD_PROG);
    op(1, A0, 16'h0000);
    idle;
    op(0, A0, 16'h0);
    chk(got, 16'h1234);
    seq(A0, CMD_LOCK_CLEAR);
    lockst(16'h0);
    seq(A0, CMD_LOCK_SET);
    seq(A0, CMD_LOCKREG_PROG);
    lockst(16'h0);
    @(posedge clk) prot <= 0;
    seq(A0, CMD_WORD_PROG);
    op(1, A0, 16'h0000);
    idle;
    op(0, A0, 16'h0);
    chk(got, 16'h1234);
    @(posedge clk) prot <= 1;
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    s_rww;
    s_abort;
    s_ident;
    s_lock;
    close_out;
  end
  // about 50k cycles, several times the expected run
  initial begin
    #200000;
    num_errors++;
    close_out;
  end
endmodule // flash_write_buffer_protect_tb_top

// >>> dv/fwbp_props.sv
// concurrent checks on the flash pins between host controller and device
module fwbp_props (
  input wire logic CORE_CLK, // 250 MHz clock
  input wire logic RST, // sync reset, high
  input wire logic chip_enable_n, // select, low
  input wire logic address_valid_n, // address strobe, low
  input wire logic write_enable_n, // write strobe, low
  input wire logic output_enable_n, // read strobe, low
  input wire logic host_adq_oe, // host drives the shared lines
  input wire logic dev_adq_oe, // device drives the shared lines
  input wire logic rdy // device data valid
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  chk_rdy_after_oe: assert property ($fell(output_enable_n) && !chip_enable_n |-> !rdy ##[2:4] rdy)
    else $error("ready did not follow the read strobe");
  chk_rdy_rise_oe: assert property ($rose(rdy) |-> !output_enable_n && !chip_enable_n)
    else $error("ready rose without a read");
  chk_addr_phase: assert property (!address_valid_n |-> !chip_enable_n && output_enable_n)
    else $error("address phase with bad strobes");
  chk_write_phase: assert property (!write_enable_n |-> !chip_enable_n && output_enable_n)
    else $error("write phase with bad strobes");
  chk_addr_then_wr: assert property ($fell(write_enable_n) |-> !$past(address_valid_n))
    else $error("write without a preceding address");
  chk_wr_one_cyc: assert property ($fell(write_enable_n) |=> write_enable_n)
    else $error("write strobe longer than one cycle");
  chk_no_clash: assert property (!(host_adq_oe && dev_adq_oe))
    else $error("both ends drive the shared lines");
  chk_dev_drive: assert property ($rose(dev_adq_oe) |-> !rdy)
    else $error("ready already high when the device began to drive");
endmodule // fwbp_props
